/* File: rtl/swd_pkg.sv */
// Purpose: shared constants, types and state layout for the software
//          watchdog timer.
// Assumes: 8-bit special-function register space, one system clock.
// Notes:   offsets are byte addresses in that space.
package swd_pkg;

  // register space geometry
  localparam int unsigned SWD_ADDR_W = 8;
  localparam int unsigned SWD_DATA_W = 8;

  // register offsets
  localparam logic [7:0] SWD_RELOAD_ADDR = 8'h86;
  localparam logic [7:0] SWD_INTERRUPT_ENABLE_ZERO_ADDR = 8'hA8;
  localparam logic [7:0] SWD_IP0_ADDR = 8'hA9;
  localparam logic [7:0] SWD_CTRL_ADDR = 8'hF9;
  localparam logic [7:0] SWD_EVT_STAT_ADDR = 8'hFA;
  localparam logic [7:0] SWD_EVT_MASK_ADDR = 8'hFB;

  // field positions
  localparam int unsigned SWD_PSEL_BIT = 7;
  localparam int unsigned SWD_REFRESH_BIT = 6;
  localparam int unsigned SWD_EXPIRY_BIT = 6;
  localparam int unsigned SWD_START_BIT = 0;
  localparam int unsigned SWD_RUN_RD_BIT = 1;
  localparam int unsigned SWD_PEND_RD_BIT = 2;
  localparam int unsigned SWD_RELOAD_HI_W = 7;

  // event bits of the status and mask registers
  localparam int unsigned SWD_EVT_W = 3;
  localparam int unsigned SWD_EVT_EXPIRE = 0;
  localparam int unsigned SWD_EVT_RELOAD = 1;
  localparam int unsigned SWD_EVT_LAPSE = 2;

  // reset values
  localparam logic [7:0] SWD_REG_RESET = 8'h00;
  localparam logic [7:0] SWD_LOW_BYTE_CLR = 8'h00;
  localparam logic [7:0] SWD_READ_ZERO = 8'h00;

  // timing, in system clock cycles
  localparam logic [3:0] SWD_MC_DIV = 4'hC;        // clocks per machine cycle
  localparam logic [0:0] SWD_PRE_A_LAST = 1'h1;    // divide-by-2 stage
  localparam logic [3:0] SWD_PRE_B_LAST = 4'hF;    // divide-by-16 stage
  localparam int unsigned SWD_REFRESH_WIN = 12;
  localparam logic [15:0] SWD_EXPIRE_VAL = 16'h7CFF;

  // run state of the watchdog
  typedef enum logic [0:0] {
    SWD_STOPPED = 1'b0,
    SWD_RUNNING = 1'b1
  } swd_run_e;

  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [SWD_ADDR_W-1:0] addr;
    logic [SWD_DATA_W-1:0] wdata;
  } swd_bus_req_s;

  // complete state of the watchdog block
  typedef struct packed {
    swd_run_e run;
    logic [15:0] cnt;
    logic [3:0] mc;
    logic [0:0] pa;
    logic [3:0] pb;
    logic [3:0] win;
    logic [7:0] reload;
    logic [7:0] interrupt_enable_zero;
    logic [7:0] ip0;
    logic [SWD_EVT_W-1:0] evt;
    logic [SWD_EVT_W-1:0] mask;
    logic [7:0] rdata;
    logic exp;
    logic irq;
  } swd_state_s;

endpackage

/* File: rtl/swd_watchdog.sv */
// Purpose: software watchdog timer with reload register, two-write
//          refresh sequence, sticky expiry flag and reset request.
// Assumes: register port on the system clock; resets are synchronous.
// Notes:   the watchdog-caused reset spares the expiry flag so firmware
//          can tell why it restarted.

// Summary of operation
// (RULE1) 16-bit counter, step every 24 or 384
// (RULE2) divide-by-2 then optional divide-by-16 prescale
// (RULE3) after reset: stopped, everything zero
// (RULE4) software cannot stop it once running
// (RULE5) writing start bit begins counting
// (RULE6) counter at 0x7CFF raises expiry status
// (RULE7) expiry sets priority bit 6, requests reset
// (RULE8) expiry drops on reset or counter change
// (RULE9) start must follow refresh within 12 cycles
// (RULE10) refresh lapses after 12 cycles, no reload
// (RULE11) start inside window reloads, clears refresh
// (RULE12) expiry flag survives own reset, clearable
// (RULE13) reload bit 7 adds divide-by-16 stage
// (RULE14) reload bits 6..0 load counter high byte
// (RULE15) enable bit 6 is refresh, not masking
// (RULE16) refresh clears low byte and top bit
// (RULE17) start bit reads zero after acting
module swd_watchdog
  import swd_pkg::*;
#(
  parameter int unsigned REFRESH_WIN = SWD_REFRESH_WIN
) (
  // clock and resets
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic wdog_rst_b_i,
  // register port
  input wire swd_bus_req_s bus_i,
  output logic [SWD_DATA_W-1:0] rdata_o,
  // status and requests
  output logic running_o,
  output logic expiry_o,
  output logic reset_req_o,
  output logic irq_o
);

  // the window counter is four bits wide
  generate
    if (REFRESH_WIN < 1 || REFRESH_WIN > 15) begin : g_bad_win
      $error("REFRESH_WIN must lie in 1..15");
    end
  endgenerate

  localparam logic [3:0] WIN_LAST = 4'(REFRESH_WIN - 1);

  swd_state_s st_reg;
  swd_state_s st_next;

  logic mc_wrap;
  logic pa_wrap;
  logic pb_wrap;
  logic tick;
  logic wr_interrupt_enable_zero;
  logic wr_start;
  logic do_reload;
  logic lapse;

  // address match of a request; used by the write decode, the read decode has its own case
  function automatic logic hit(input swd_bus_req_s req,
                               input logic [7:0] target);
    hit = (req.addr == target);
  endfunction

  // prescaler chain: machine cycle, divide-by-2, optional divide-by-16
  always_comb begin
    // (RULE2) fixed then optional
    mc_wrap = (st_reg.mc == SWD_MC_DIV - 4'h1);
    pa_wrap = mc_wrap && (st_reg.pa == SWD_PRE_A_LAST);
    pb_wrap = pa_wrap && (st_reg.pb == SWD_PRE_B_LAST);
    // (RULE13) prescale select steers
    // (RULE1) one step per 24/384
    tick = (st_reg.run == SWD_RUNNING) &&
           (st_reg.reload[SWD_PSEL_BIT] ? pb_wrap : pa_wrap);
  end

  // refresh sequence decode
  always_comb begin
    wr_interrupt_enable_zero = bus_i.wr && hit(bus_i, SWD_INTERRUPT_ENABLE_ZERO_ADDR);
    // (RULE5) start bit write
    wr_start = bus_i.wr && hit(bus_i, SWD_CTRL_ADDR) &&
               bus_i.wdata[SWD_START_BIT];
    // (RULE11) start inside window
    do_reload = wr_start && st_reg.interrupt_enable_zero[SWD_REFRESH_BIT];
    // (RULE10) window ran out
    lapse = st_reg.interrupt_enable_zero[SWD_REFRESH_BIT] && !wr_start &&
            (st_reg.win == WIN_LAST);
  end

  // next state of the whole block
  always_comb begin
    st_next = st_reg;

    // (RULE4) only a start, never a stop
    if (wr_start) begin
      st_next.run = SWD_RUNNING;
    end

    // prescalers only move while running
    if (st_reg.run == SWD_RUNNING) begin
      st_next.mc = mc_wrap ? 4'h0 : st_reg.mc + 4'h1;
      if (mc_wrap) begin
        st_next.pa = st_reg.pa + 1'h1;
      end
      if (pa_wrap && st_reg.reload[SWD_PSEL_BIT]) begin
        st_next.pb = st_reg.pb + 4'h1;
      end
    end

    // counter: reload wins over a step; wraps past all ones
    if (do_reload) begin
      // (RULE14) high byte from reload
      // (RULE16) low byte and msb cleared
      st_next.cnt = {1'b0, st_reg.reload[SWD_RELOAD_HI_W-1:0],
                     SWD_LOW_BYTE_CLR};
      st_next.mc = 4'h0;
      st_next.pa = 1'h0;
      st_next.pb = 4'h0;
    end else if (tick) begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end

    // register writes; refresh bit is set by software, cleared by us
    if (bus_i.wr && hit(bus_i, SWD_RELOAD_ADDR)) begin
      st_next.reload = bus_i.wdata;
    end
    // (RULE15) refresh bit, set only
    if (wr_interrupt_enable_zero) begin
      st_next.interrupt_enable_zero = bus_i.wdata;
      st_next.interrupt_enable_zero[SWD_REFRESH_BIT] = st_reg.interrupt_enable_zero[SWD_REFRESH_BIT] |
                                      bus_i.wdata[SWD_REFRESH_BIT];
    end
    if (bus_i.wr && hit(bus_i, SWD_IP0_ADDR)) begin
      st_next.ip0 = bus_i.wdata;
    end
    if (bus_i.wr && hit(bus_i, SWD_EVT_MASK_ADDR)) begin
      st_next.mask = bus_i.wdata[SWD_EVT_W-1:0];
    end

    // window timing for a pending refresh
    if (wr_interrupt_enable_zero && bus_i.wdata[SWD_REFRESH_BIT] &&
        !st_reg.interrupt_enable_zero[SWD_REFRESH_BIT]) begin
      st_next.win = 4'h0;
    end else if (st_reg.interrupt_enable_zero[SWD_REFRESH_BIT]) begin
      st_next.win = st_reg.win + 4'h1;
    end
    // (RULE9) start needed within window
    // (RULE10) self-clear, no reload
    // (RULE11) clear after reload
    if (lapse || do_reload) begin
      st_next.interrupt_enable_zero[SWD_REFRESH_BIT] = 1'b0;
      st_next.win = 4'h0;
    end

    // (RULE6) expiry tracks counter value
    // (RULE8) drops once counter moves
    st_next.exp = (st_next.run == SWD_RUNNING) &&
                  (st_next.cnt == SWD_EXPIRE_VAL);

    // (RULE7) expiry sets priority bit 6
    // (RULE12) set wins over software clear
    if (st_reg.exp) begin
      st_next.ip0[SWD_EXPIRY_BIT] = 1'b1;
    end

    // sticky events, write one to clear, a new event wins the clear
    if (bus_i.wr && hit(bus_i, SWD_EVT_STAT_ADDR)) begin
      st_next.evt = st_reg.evt & ~bus_i.wdata[SWD_EVT_W-1:0];
    end
    if (st_reg.exp) begin
      st_next.evt[SWD_EVT_EXPIRE] = 1'b1;
    end
    if (do_reload) begin
      st_next.evt[SWD_EVT_RELOAD] = 1'b1;
    end
    if (lapse) begin
      st_next.evt[SWD_EVT_LAPSE] = 1'b1;
    end
    st_next.irq = |(st_next.evt & st_next.mask);

    // read data stand one cycle after the strobe; unmapped reads zero
    st_next.rdata = SWD_READ_ZERO;
    if (bus_i.rd) begin
      case (bus_i.addr)
        SWD_RELOAD_ADDR: st_next.rdata = st_reg.reload;
        SWD_INTERRUPT_ENABLE_ZERO_ADDR: st_next.rdata = st_reg.interrupt_enable_zero;
        SWD_IP0_ADDR: st_next.rdata = st_reg.ip0;
        // (RULE17) start reads back zero
        SWD_CTRL_ADDR: begin
          st_next.rdata[SWD_RUN_RD_BIT] = (st_reg.run == SWD_RUNNING);
          st_next.rdata[SWD_PEND_RD_BIT] = st_reg.interrupt_enable_zero[SWD_REFRESH_BIT];
        end
        SWD_EVT_STAT_ADDR: st_next.rdata[SWD_EVT_W-1:0] = st_reg.evt;
        SWD_EVT_MASK_ADDR: st_next.rdata[SWD_EVT_W-1:0] = st_reg.mask;
        default: st_next.rdata = SWD_READ_ZERO;
      endcase
    end

    // (RULE12) own reset spares expiry flag
    if (!wdog_rst_b_i) begin
      st_next = '0;
      st_next.ip0[SWD_EXPIRY_BIT] = st_reg.ip0[SWD_EXPIRY_BIT];
    end
  end

  // state register; full reset clears everything
  always_ff @(posedge core_clk_i) begin
    // (RULE3) all zero, stopped
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  always_comb begin
    rdata_o = st_reg.rdata;
    running_o = (st_reg.run == SWD_RUNNING);
    expiry_o = st_reg.exp;
    // (RULE7) expiry requests reset
    reset_req_o = st_reg.exp;
    irq_o = st_reg.irq;
  end

endmodule

/* File: tb/swd_watchdog_properties.sv */
// Purpose: port-level checks of the software watchdog
// Assumes: one clock, both resets synchronous active low
// Notes: bound into every swd_watchdog instance
module swd_watchdog_properties
  import swd_pkg::*;
(
  // clock and resets
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic wdog_rst_b_i,
  // observed ports
  input wire swd_bus_req_s bus_i,
  input wire logic [SWD_DATA_W-1:0] rdata_o,
  input wire logic running_o,
  input wire logic expiry_o,
  input wire logic reset_req_o,
  input wire logic irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i || !wdog_rst_b_i);
  logic [9:0] hold_reg;
  logic [9:0] hold_next;
  // run length of expiry; a counter step takes at most 384 clocks
  always_comb hold_next = expiry_o ? hold_reg + 10'h001 : 10'h000;
  always_ff @(posedge core_clk_i) hold_reg <= hold_next;

  a_reset_clears: assert property (disable iff (1'b0)
    !(rst_b_i && wdog_rst_b_i) |=> !running_o && !expiry_o && !irq_o)
    else $error("outputs not cleared by reset");
  a_req_follows: assert property (reset_req_o == expiry_o)
    else $error("reset request differs from expiry");
  a_start_runs: assert property (
    bus_i.wr && bus_i.addr == SWD_CTRL_ADDR && bus_i.wdata[0] |=> running_o)
    else $error("start write did not start counting");
  a_no_halt: assert property (running_o |=> running_o)
    else $error("watchdog stopped without reset");
  a_read_idle: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  a_ctrl_read: assert property (
    bus_i.rd && bus_i.addr == SWD_CTRL_ADDR |=> !rdata_o[SWD_START_BIT]
    && rdata_o[SWD_RUN_RD_BIT] == $past(running_o))
    else $error("control read wrong");
  a_exp_running: assert property (expiry_o |-> running_o)
    else $error("expiry while stopped");
  a_exp_bound: assert property (hold_reg <= 10'd384)
    else $error("expiry held past a counter step");
  a_exp_hold: assert property (
    $rose(expiry_o) && !bus_i.wr |=> expiry_o[*2])
    else $error("counter stepped too early");
endmodule

bind swd_watchdog swd_watchdog_properties swd_watchdog_properties_inst (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdog_rst_b_i(wdog_rst_b_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .running_o(running_o),
  .expiry_o(expiry_o), .reset_req_o(reset_req_o), .irq_o(irq_o));

/* File: tb/software_watchdog_timer_test.sv */
// Purpose: self-checking bench of the software watchdog
// Assumes: 40 MHz clock, register port with one-cycle strobes
// Notes: the divide-by-16 path is only checked for not expiring early
module software_watchdog_timer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import swd_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wdog_rst_b_i = 1'b1;
  swd_bus_req_s bus_i = '0;
  logic [7:0] rdata_o;
  logic running_o, expiry_o, reset_req_o, irq_o;
  int checks = 0;
  int fail_count = 0;
  int n;
  logic [7:0] v;
  logic [7:0] addrs [7] = '{8'h86, 8'hA8, 8'hA9, 8'hF9, 8'hFA, 8'hFB, 8'h55};

  swd_watchdog #(.REFRESH_WIN(SWD_REFRESH_WIN)) swd_watchdog_inst (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wdog_rst_b_i(wdog_rst_b_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .running_o(running_o),
    .expiry_o(expiry_o), .reset_req_o(reset_req_o), .irq_o(irq_o));

  // free-running system clock
  initial forever #12.5 core_clk_i = ~core_clk_i;

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one write cycle; strobe dropped at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus_i.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    @(posedge core_clk_i);
    bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    bus_i.rd <= 1'b0;
    #1 chk(rdata_o & m, e);
  endtask

  // clocks from a reload to expiry: steps times clocks per step
  function automatic int exp_cycles(input logic [7:0] rel);
    return int'(SWD_EXPIRE_VAL - {1'b0, rel[6:0], 8'h00})
      * (rel[7] ? 384 : 24);
  endfunction

  // hang guard, well beyond the two long waits
  initial begin
    #(25 * 20000);
    fail_count++;
    results();
  end

  initial begin
    void'($urandom(15));
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'hFF, 8'h00);
    // random contents; refresh bit kept clear so reads are stable
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom()) & 8'hBF;
      wr(SWD_RELOAD_ADDR, v);
      rd(SWD_RELOAD_ADDR, 8'hFF, v);
      wr(SWD_IP0_ADDR, v);
      rd(SWD_IP0_ADDR, 8'hFF, v);
      wr(SWD_INTERRUPT_ENABLE_ZERO_ADDR, v);
      rd(SWD_INTERRUPT_ENABLE_ZERO_ADDR, 8'hFF, v);
    end
    // refresh bit left alone lapses by itself
    wr(SWD_INTERRUPT_ENABLE_ZERO_ADDR, 8'h40);
    rd(SWD_CTRL_ADDR, 8'h04, 8'h04);
    repeat (13) @(posedge core_clk_i);
    rd(SWD_INTERRUPT_ENABLE_ZERO_ADDR, 8'h40, 8'h00);
    rd(SWD_EVT_STAT_ADDR, 8'h04, 8'h04);
    rd(SWD_CTRL_ADDR, 8'h07, 8'h00);
    // start, then a stop attempt that must be ignored
    wr(SWD_EVT_MASK_ADDR, 8'h01);
    wr(SWD_EVT_STAT_ADDR, 8'h07);
    wr(SWD_CTRL_ADDR, 8'h01);
    wr(SWD_CTRL_ADDR, 8'h00);
    rd(SWD_CTRL_ADDR, 8'h07, 8'h02);
    // refresh close to the expiry value and time the expiry
    wr(SWD_RELOAD_ADDR, 8'h7C);
    wr(SWD_INTERRUPT_ENABLE_ZERO_ADDR, 8'h40);
    wr(SWD_CTRL_ADDR, 8'h01);
    n = 0;
    while (!expiry_o && n < 8000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk(8'(n / 24), 8'(exp_cycles(8'h7C) / 24));
    chk(8'(n % 24), 8'h00);
    chk({7'h00, reset_req_o}, 8'h01);
    rd(SWD_IP0_ADDR, 8'h40, 8'h40);
    chk({7'h00, irq_o}, 8'h01);
    rd(SWD_EVT_STAT_ADDR, 8'h02, 8'h02);
    // clear only after the counter moved on, else the set wins again
    repeat (24) @(posedge core_clk_i);
    #1 chk({7'h00, expiry_o}, 8'h00);
    wr(SWD_EVT_STAT_ADDR, 8'h01);
    rd(SWD_EVT_STAT_ADDR, 8'h01, 8'h00);
    chk({7'h00, irq_o}, 8'h00);
    // the watchdog's own reset spares the expiry flag
    @(posedge core_clk_i);
    wdog_rst_b_i <= 1'b0;
    @(posedge core_clk_i);
    wdog_rst_b_i <= 1'b1;
    rd(SWD_CTRL_ADDR, 8'h02, 8'h00);
    rd(SWD_IP0_ADDR, 8'h40, 8'h40);
    wr(SWD_IP0_ADDR, 8'h00);
    rd(SWD_IP0_ADDR, 8'h40, 8'h00);
    // extra prescaler: same reload must not expire in the short time
    wr(SWD_RELOAD_ADDR, 8'hFC);
    wr(SWD_CTRL_ADDR, 8'h01);
    wr(SWD_INTERRUPT_ENABLE_ZERO_ADDR, 8'h40);
    wr(SWD_CTRL_ADDR, 8'h01);
    repeat (exp_cycles(8'h7C) + 8) @(posedge core_clk_i);
    #1 chk({7'h00, expiry_o}, 8'h00);
    results();
  end
endmodule
